// ===== logic/wdsup_pkg.sv
// Package of constants for the window watchdog supervisor.
package wdsup_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    // Reference oscillator rate at the reference resistor setting, in Hz.
    localparam int unsigned REF_OSC_HZ    = 100_000;
    localparam int unsigned OSC_MIN_HZ    = 50_000;
    localparam int unsigned OSC_MAX_HZ    = 250_000;
    // Accepted edge spacing at the reference setting, in microseconds.
    localparam int unsigned WIN_MIN_US    = 1773;
    localparam int unsigned WIN_MAX_US    = 6920;
    // Window bounds in oscillator ticks: least rounds up, longest rounds down.
    localparam int unsigned WIN_MIN_TICKS =
        (WIN_MIN_US * (REF_OSC_HZ / 1000) + 999) / 1000;
    localparam int unsigned WIN_MAX_TICKS =
        (WIN_MAX_US * (REF_OSC_HZ / 1000)) / 1000;
    // Power-on reset delay default, in microseconds, and its cycle count.
    localparam int unsigned POR_US        = 14000;
    localparam int unsigned POR_CYCLES    = POR_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OSC_DIV_DEF   = CLK_HZ / REF_OSC_HZ;
    localparam logic        RST_OUT_Q     = 1'b0;
endpackage : wdsup_pkg

// ===== logic/wdsup_osc.sv
// Divider that makes the watchdog timebase tick enable.
module wdsup_osc #(
    parameter int unsigned DIV_W = 12
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [DIV_W-1:0] div_cycles,
    output logic                  tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_d;

    // The counter needs at least two bits to divide at all.
    if (DIV_W < 2)
    begin : g_bad_width
        $error("wdsup_osc: DIV_W too small");
    end

    always_comb
    begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= div_cycles)
        begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule // wdsup_osc

// ===== logic/wdsup_top.sv
// Window watchdog with open-drain supervisory outputs.
// Summary of operation
// - Accept edge spacing 1.773 to 6.920 ms
// - Oscillator 50 to 250 kHz scales window
// - Enable pin defaults high when open
// - Enable low keeps watchdog reset high
// - Watchdog reset falls on bad timing
// - Open-drain outputs low on fault
// - Outputs wire-OR into one fault line
// - Power-on reset delay is configurable
module wdsup_top #(
    parameter int unsigned POR_CYCLES = wdsup_pkg::POR_CYCLES,
    parameter int unsigned TICK_W     = 12
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wd_clk_in,
    input  wire logic        watchdog_enable_pin,
    input  wire logic [11:0] watchdog_freq_set_pin,
    input  wire logic        buck_ok,
    input  wire logic        ldo_ok,
    output logic             watchdog_reset_out,
    output logic             watchdog_reset_out_oe,
    output logic             buck_power_good_out,
    output logic             buck_power_good_out_oe,
    output logic             ldo_power_good_out,
    output logic             ldo_power_good_out_oe,
    output logic             ldo_reset_out,
    output logic             ldo_reset_out_oe,
    output logic             fault_line
);
    localparam int unsigned DIV_MIN = wdsup_pkg::CLK_HZ /
                                      wdsup_pkg::OSC_MAX_HZ;
    localparam int unsigned DIV_MAX = wdsup_pkg::CLK_HZ /
                                      wdsup_pkg::OSC_MIN_HZ;
    localparam logic [TICK_W-1:0] T_MIN = TICK_W'(wdsup_pkg::WIN_MIN_TICKS);
    localparam logic [TICK_W-1:0] T_MAX = TICK_W'(wdsup_pkg::WIN_MAX_TICKS);

    // The window bounds need ten bits and the delay must be nonzero.
    if (TICK_W < 10 || POR_CYCLES < 1)
    begin : g_bad_param
        $error("wdsup_top: unsupported parameters");
    end

    logic [2:0]        clk_s_q;
    logic [2:0]        clk_s_d;
    logic [1:0]        en_s_q;
    logic [1:0]        en_s_d;
    logic [1:0]        bk_s_q;
    logic [1:0]        bk_s_d;
    logic [1:0]        lo_s_q;
    logic [1:0]        lo_s_d;
    logic [11:0]       div_q;
    logic [11:0]       div_d;
    logic [11:0]       fs_a_q;
    logic [11:0]       fs_a_d;
    logic [11:0]       fs_b_q;
    logic [11:0]       fs_b_d;
    logic              tick;
    logic [31:0]       por_q;
    logic [31:0]       por_d;
    logic              por_done;
    logic [TICK_W-1:0] tcnt_q;
    logic [TICK_W-1:0] tcnt_d;
    logic              armed_q;
    logic              armed_d;
    logic              wdf_q;
    logic              wdf_d;
    logic              edge_seen;
    logic              wd_en;

    // The frequency select is clamped into the legal oscillator range.
    always_comb
    begin
        clk_s_d = {clk_s_q[1:0], wd_clk_in};
        en_s_d  = {en_s_q[0], watchdog_enable_pin};
        bk_s_d  = {bk_s_q[0], buck_ok};
        lo_s_d  = {lo_s_q[0], ldo_ok};
        por_d   = por_done ? por_q : por_q + 32'h1;
        // The resistor setting is a pin: two flip-flops come before the clamp.
        fs_a_d  = watchdog_freq_set_pin;
        fs_b_d  = fs_a_q;
        if (fs_b_q < 12'(DIV_MIN))
            div_d = 12'(DIV_MIN);
        else if (fs_b_q > 12'(DIV_MAX))
            div_d = 12'(DIV_MAX);
        else
            div_d = fs_b_q;
    end

    // The reset delay counter holds once the delay has run out.
    assign por_done  = (por_q >= POR_CYCLES);
    assign edge_seen = clk_s_q[2] ^ clk_s_q[1];
    assign wd_en     = en_s_q[1];

    wdsup_osc #(
        .DIV_W      (12)
    ) u_osc (
        .mclk       (mclk),
        .rst        (rst),
        .div_cycles (div_q),
        .tick       (tick)
    );

    // Window check counts oscillator ticks between successive edges.
    always_comb
    begin
        tcnt_d  = tcnt_q;
        armed_d = armed_q;
        wdf_d   = wdf_q;
        if (!wd_en || !por_done)
        begin
            tcnt_d  = '0;
            armed_d = 1'b0;
            wdf_d   = 1'b0;
        end
        else if (!wdf_q)
        begin
            // An edge in the same cycle as a tick wins; that tick is lost.
            if (edge_seen)
            begin
                if (armed_q && tcnt_q < T_MIN)
                    wdf_d = 1'b1;
                tcnt_d  = '0;
                armed_d = 1'b1;
            end
            else if (tick)
            begin
                if (tcnt_q >= T_MAX)
                    wdf_d = 1'b1;
                else
                    tcnt_d = tcnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            clk_s_q <= 3'h0;
            en_s_q  <= 2'h3;
            bk_s_q  <= 2'h0;
            lo_s_q  <= 2'h0;
            por_q   <= 32'h0;
            tcnt_q  <= '0;
            armed_q <= 1'b0;
            wdf_q   <= 1'b0;
            fs_a_q  <= 12'(wdsup_pkg::OSC_DIV_DEF);
            fs_b_q  <= 12'(wdsup_pkg::OSC_DIV_DEF);
            div_q   <= 12'(wdsup_pkg::OSC_DIV_DEF);
        end
        else
        begin
            clk_s_q <= clk_s_d;
            en_s_q  <= en_s_d;
            bk_s_q  <= bk_s_d;
            lo_s_q  <= lo_s_d;
            por_q   <= por_d;
            tcnt_q  <= tcnt_d;
            armed_q <= armed_d;
            wdf_q   <= wdf_d;
            fs_a_q  <= fs_a_d;
            fs_b_q  <= fs_b_d;
            div_q   <= div_d;
        end
    end

    // Open drain: output data is always low, enable pulls the pin down.
    assign watchdog_reset_out     = wdsup_pkg::RST_OUT_Q;
    assign buck_power_good_out    = wdsup_pkg::RST_OUT_Q;
    assign ldo_power_good_out     = wdsup_pkg::RST_OUT_Q;
    assign ldo_reset_out          = wdsup_pkg::RST_OUT_Q;
    assign watchdog_reset_out_oe  = wdf_q;
    assign buck_power_good_out_oe = !bk_s_q[1];
    assign ldo_power_good_out_oe  = !lo_s_q[1];
    assign ldo_reset_out_oe       = !por_done || !lo_s_q[1];
    assign fault_line = watchdog_reset_out_oe | buck_power_good_out_oe |
                        ldo_power_good_out_oe | ldo_reset_out_oe;

    // Checks on the window timer and the supervisory outputs.
    dis_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !en_s_q[1] |=> !watchdog_reset_out_oe)
        else $error("watchdog reset asserted while disabled");
    dis_count_a: assert property (@(posedge mclk) disable iff (rst)
        !wd_en |=> tcnt_q == '0 && !armed_q)
        else $error("window timer runs while disabled");
    late_fault_a: assert property (@(posedge mclk) disable iff (rst)
        (wd_en && por_done && !wdf_q && tick && !edge_seen
         && tcnt_q >= T_MAX) |=> wdf_q)
        else $error("late edge not flagged");
    early_fault_a: assert property (@(posedge mclk) disable iff (rst)
        (wd_en && por_done && !wdf_q && edge_seen && armed_q
         && tcnt_q < T_MIN) |=> wdf_q)
        else $error("early edge not flagged");
    first_edge_a: assert property (@(posedge mclk) disable iff (rst)
        (wd_en && por_done && !wdf_q && edge_seen && !armed_q)
        |=> !wdf_q && armed_q)
        else $error("first edge wrongly flagged");
    good_edge_a: assert property (@(posedge mclk) disable iff (rst)
        (wd_en && por_done && !wdf_q && edge_seen && tcnt_q >= T_MIN)
        |=> !wdf_q && tcnt_q == '0)
        else $error("in-window edge wrongly flagged");
    fault_sticky_a: assert property (@(posedge mclk) disable iff (rst)
        (wdf_q && wd_en && por_done) |=> wdf_q)
        else $error("watchdog fault released early");
    wired_or_a: assert property (@(posedge mclk) disable iff (rst)
        !ldo_ok ##1 !ldo_ok ##1 !ldo_ok |-> fault_line)
        else $error("fault line not low on rail fault");
    por_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !por_done |-> ldo_reset_out_oe && !watchdog_reset_out_oe)
        else $error("reset delay not held");
    div_range_a: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) |-> div_q >= 12'(DIV_MIN) && div_q <= 12'(DIV_MAX))
        else $error("oscillator divider out of range");
    tick_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        tick |=> !tick)
        else $error("oscillator tick longer than one cycle");
    pg_follow_a: assert property (@(posedge mclk) disable iff (rst)
        !buck_ok ##1 !buck_ok ##1 !buck_ok |-> buck_power_good_out_oe)
        else $error("buck power good not pulled low");
endmodule // wdsup_top

// ===== tb/wdsup_mcu.sv
// Controller model that toggles the watchdog clock at a set spacing.
module wdsup_mcu (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [31:0] period,
    output logic             wd_clk = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt   = '0;
    logic        run_q = 1'b0;
    // The clock stands still while run is low.
    always @(negedge mclk)
    begin
        run_q <= run;
        if (rst)
        begin
            wd_clk <= 1'b0;
            cnt    <= '0;
        end
        else if (run && !run_q)
            cnt <= period - 32'h0000000a;
        else if (run)
        begin
            cnt <= cnt + 32'h00000001;
            if (cnt >= period)
            begin
                wd_clk <= ~wd_clk;
                cnt    <= 32'h00000001;
            end
        end
    end
endmodule // wdsup_mcu

// ===== tb/window_watchdog_supervisor_tb.sv
// Self-checking testbench for the window watchdog supervisor.
module window_watchdog_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned POR_SIM = 100;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        wd_clk, en = 1'b1, buck_ok = 1'b1, ldo_ok = 1'b1;
    logic        run = 1'b0;
    logic [31:0] period = 32'h00011940;
    // A select below the legal range must clamp to the fastest oscillator.
    logic [11:0] fsel   = 12'h064;
    logic        wd_o, wd_oe, bpg_o, bpg_oe, lpg_o, lpg_oe, lr_o, lr_oe;
    logic        fault;
    int          n_fail = 0;
    int          comparisons = 0;
    always #5 mclk = ~mclk;
    wdsup_mcu i_mcu (.mclk(mclk), .rst(rst), .run(run), .period(period),
        .wd_clk(wd_clk));
    wdsup_top #(.POR_CYCLES(POR_SIM)) i_dut (.mclk(mclk), .rst(rst),
        .wd_clk_in(wd_clk), .watchdog_enable_pin(en),
        .watchdog_freq_set_pin(fsel), .buck_ok(buck_ok), .ldo_ok(ldo_ok),
        .watchdog_reset_out(wd_o), .watchdog_reset_out_oe(wd_oe),
        .buck_power_good_out(bpg_o), .buck_power_good_out_oe(bpg_oe),
        .ldo_power_good_out(lpg_o), .ldo_power_good_out_oe(lpg_oe),
        .ldo_reset_out(lr_o), .ldo_reset_out_oe(lr_oe),
        .fault_line(fault));
    task automatic check(input string name, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic finish_test;
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_por;
        check("lr_oe_por", lr_oe, 1'b1);
        check("wd_oe_idle", wd_oe, 1'b0);
        wait_cyc(POR_SIM + 20);
        check("lr_oe_done", lr_oe, 1'b0);
        check("drain_data", wd_o | bpg_o | lpg_o | lr_o, 1'b0);
        check("fault_idle", fault, 1'b0);
    endtask
    task automatic t_rails;
        buck_ok = 1'b0;
        wait_cyc(6);
        check("bpg_oe_bad", bpg_oe, 1'b1);
        check("fault_buck", fault, 1'b1);
        buck_ok = 1'b1;
        wait_cyc(6);
        check("bpg_oe_ok", bpg_oe, 1'b0);
        check("fault_clear", fault, 1'b0);
        ldo_ok = 1'b0;
        wait_cyc(6);
        check("lpg_oe_bad", lpg_oe, 1'b1);
        check("lr_oe_bad", lr_oe, 1'b1);
        ldo_ok = 1'b1;
        wait_cyc(POR_SIM + 20);
        check("lpg_oe_ok", lpg_oe, 1'b0);
        check("lr_oe_ok", lr_oe, 1'b0);
    endtask
    // Spacing of 180 ticks is accepted, then 10 ticks is too short.
    task automatic t_window;
        run <= 1'b1;
        wait_cyc(72040);
        check("wd_oe_good", wd_oe, 1'b0);
        period <= 32'h00000fa0;
        wait_cyc(4100);
        check("wd_oe_early", wd_oe, 1'b1);
        check("fault_wd", fault, 1'b1);
        run <= 1'b0;
    endtask
    task automatic t_disable;
        en = 1'b0;
        wait_cyc(6);
        check("wd_oe_off", wd_oe, 1'b0);
        period <= 32'h000001f4;
        run <= 1'b1;
        wait_cyc(2100);
        check("wd_oe_off_run", wd_oe, 1'b0);
        check("fault_off", fault, 1'b0);
    endtask
    initial
    begin
        repeat (8) @(negedge mclk);
        rst <= 1'b0;
        t_por();
        t_rails();
        t_window();
        t_disable();
        finish_test();
    end
    initial
    begin
        #1_000_000;
        n_fail++;
        finish_test();
    end
endmodule // window_watchdog_supervisor_tb
